// [src/kpm_panel.sv]
// Chosen here: the placing of the registers and the APB slave port.
module kpm_panel #(
  parameter int unsigned TICK_CYC = kpm_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Operator keys, one level per key
  input wire logic [7:0] keys_in,
  // Drive state and status quantity
  input wire kpm_pkg::kpm_drive_s drive_in,
  input wire logic [19:0] status_value_in,
  input wire logic [2:0] status_unit_in,
  // Lamps and display
  output kpm_pkg::kpm_lamps_s lamps_out,
  output logic [19:0] digits_out,
  output logic [4:0] digit_dark_out,
  output logic [3:0] status_sel_out,
  // Drive commands
  output logic run_cmd_out,
  output logic stop_cmd_out,
  output logic fault_reset_out,
  output logic reverse_cmd_out,
  output logic [1:0] cmd_src_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] bcd_step(input logic [3:0] d,
                                          input logic up);
    if (up)
    begin
      bcd_step = (d >= 4'h9) ? 4'h0 : 4'(d + 4'h1);
    end
    else
    begin
      bcd_step = (d == 4'h0) ? 4'h9 : 4'(d - 4'h1);
    end
  endfunction

  // Steps to the next visible group; the general group is always shown.
  function automatic logic [1:0] grp_step(input logic [1:0] g,
                                          input logic up,
                                          input logic enh,
                                          input logic mon);
    logic [1:0] n;
    n = kpm_pkg::G_GEN;
    case (g)
      kpm_pkg::G_GEN:
        if (up)
          n = enh ? kpm_pkg::G_ENH : (mon ? kpm_pkg::G_MON : g);
        else
          n = mon ? kpm_pkg::G_MON : (enh ? kpm_pkg::G_ENH : g);
      kpm_pkg::G_ENH:
        n = (up && mon) ? kpm_pkg::G_MON : kpm_pkg::G_GEN;
      default:
        n = (!up && enh) ? kpm_pkg::G_ENH : kpm_pkg::G_GEN;
    endcase
    grp_step = n;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] keys_prev_reg;
  logic [16:0] tick_cnt_reg;
  logic [9:0] slow_cnt_reg;
  logic [9:0] fast_cnt_reg;
  logic slow_ph_reg;
  logic fast_ph_reg;
  logic [9:0] cfg_reg;
  logic [11:0] ro_mask_reg;
  logic [11:0] rl_mask_reg;
  logic [3:0] pidx_reg;
  logic [1:0] src_reg;
  logic [1:0] src_next;
  logic dir_reg;
  logic dir_next;
  kpm_pkg::kpm_menu_e state_reg;
  kpm_pkg::kpm_menu_e state_next;
  logic [1:0] group_reg;
  logic [1:0] group_next;
  logic [1:0] param_reg;
  logic [1:0] param_next;
  logic [19:0] edit_reg;
  logic [19:0] edit_next;
  logic [2:0] dsel_reg;
  logic [2:0] dsel_next;
  logic [3:0] ssel_next;
  logic save;
  logic [19:0] store_reg [kpm_pkg::N_PARAMS];
  logic [31:0] rdata_next;
  logic mapped;
  kpm_pkg::kpm_lamps_s lamps_next;
  logic [19:0] digits_next;
  logic [3:0] glyph;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire [7:0] press = keys_in & ~keys_prev_reg;
  wire k_menu = press[kpm_pkg::K_MENU];
  wire k_enter = press[kpm_pkg::K_ENTER];
  wire k_up = press[kpm_pkg::K_UP];
  wire k_down = press[kpm_pkg::K_DOWN];
  wire k_shift = press[kpm_pkg::K_SHIFT];
  wire tick_en = (tick_cnt_reg == 17'(TICK_CYC - 1));
  wire [3:0] idx = {group_reg, param_reg};
  wire enh_vis = (cfg_reg[7:4] == 4'h1);
  wire mon_vis = (cfg_reg[3:0] == 4'h1);
  wire editable = (group_reg != kpm_pkg::G_MON) && !ro_mask_reg[idx]
                  && !(rl_mask_reg[idx] && drive_in.running);
  wire panel_src = (src_reg == kpm_pkg::SRC_PANEL);
  wire stop_ok = cfg_reg[kpm_pkg::CFG_STOP] || panel_src;
  wire setup = psel_in && !penable_in;
  wire wr = psel_in && penable_in && pready_out && pwrite_in;
  wire wr_cfg = wr && (paddr_in == kpm_pkg::OFS_CONFIG);
  wire wr_ctrl = wr && (paddr_in == kpm_pkg::OFS_CTRL);
  wire wr_lock = wr && (paddr_in == kpm_pkg::OFS_LOCK);
  wire wr_pidx = wr && (paddr_in == kpm_pkg::OFS_PIDX);
  wire wr_pdata = wr && (paddr_in == kpm_pkg::OFS_PDATA);

  // ----------------------------------------------------------------
  // Flash dividers
  // ----------------------------------------------------------------
  // Tick and phase dividers
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      tick_cnt_reg <= 17'h00000;
      slow_cnt_reg <= 10'h000;
      fast_cnt_reg <= 10'h000;
      slow_ph_reg <= 1'b0;
      fast_ph_reg <= 1'b0;
    end
    else
    begin
      tick_cnt_reg <= tick_en ? 17'h00000 : 17'(tick_cnt_reg + 17'h1);
      if (tick_en)
      begin
        slow_cnt_reg <= (slow_cnt_reg == kpm_pkg::SLOW_TICKS - 10'h1)
                        ? 10'h000 : 10'(slow_cnt_reg + 10'h1);
        fast_cnt_reg <= (fast_cnt_reg == kpm_pkg::FAST_TICKS - 10'h1)
                        ? 10'h000 : 10'(fast_cnt_reg + 10'h1);
        if (slow_cnt_reg == kpm_pkg::SLOW_TICKS - 10'h1)
          slow_ph_reg <= !slow_ph_reg;
        if (fast_cnt_reg == kpm_pkg::FAST_TICKS - 10'h1)
          fast_ph_reg <= !fast_ph_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Menu navigation
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    group_next = group_reg;
    param_next = param_reg;
    edit_next = edit_reg;
    dsel_next = dsel_reg;
    ssel_next = status_sel_out;
    save = 1'b0;
    case (state_reg)
      kpm_pkg::M_DISP:
        if (k_menu)
          state_next = kpm_pkg::M_GROUP;
        else if (k_shift)
          ssel_next = (status_sel_out == kpm_pkg::N_STATUS - 4'h1)
                      ? 4'h0 : 4'(status_sel_out + 4'h1);
      kpm_pkg::M_GROUP:
        if (k_menu)
          state_next = kpm_pkg::M_DISP;
        else if (k_enter)
        begin
          state_next = kpm_pkg::M_PARAM;
          param_next = 2'h0;
        end
        else if (k_up || k_down)
          group_next = grp_step(group_reg, k_up, enh_vis, mon_vis);
      kpm_pkg::M_PARAM:
        if (k_menu)
          state_next = kpm_pkg::M_GROUP;
        else if (k_enter)
        begin
          state_next = kpm_pkg::M_VALUE;
          edit_next = store_reg[idx];
          dsel_next = 3'h0;
        end
        else if (k_up)
          param_next = 2'(param_reg + 2'h1);
        else if (k_down)
          param_next = 2'(param_reg - 2'h1);
      default:
        if (k_menu)
          state_next = kpm_pkg::M_PARAM;
        else if (k_enter)
        begin
          state_next = kpm_pkg::M_PARAM;
          save = editable;
          param_next = 2'(param_reg + 2'h1);
        end
        else if ((k_up || k_down) && editable)
          edit_next[{dsel_reg, 2'b00} +: 4] =
            bcd_step(edit_reg[{dsel_reg, 2'b00} +: 4], k_up);
        else if (k_shift && editable)
          dsel_next = (dsel_reg == kpm_pkg::LAST_DIGIT)
                      ? 3'h0 : 3'(dsel_reg + 3'h1);
    endcase
  end

  // A register write from the bus wins over a key in the same cycle.
  always_comb
  begin
    src_next = src_reg;
    dir_next = dir_reg;
    if (wr_ctrl)
    begin
      src_next = (pwdata_in[1:0] == 2'h3) ? kpm_pkg::SRC_PANEL
                                          : pwdata_in[1:0];
      dir_next = pwdata_in[kpm_pkg::CTRL_DIR];
    end
    else if (press[kpm_pkg::K_MFK])
    begin
      if (cfg_reg[kpm_pkg::CFG_MFK])
        dir_next = !dir_reg;
      else
        src_next = (src_reg == kpm_pkg::SRC_COMM) ? kpm_pkg::SRC_PANEL
                                                  : 2'(src_reg + 2'h1);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      keys_prev_reg <= 8'hFF;
      state_reg <= kpm_pkg::M_DISP;
      group_reg <= kpm_pkg::G_GEN;
      param_reg <= 2'h0;
      edit_reg <= 20'h00000;
      dsel_reg <= 3'h0;
      status_sel_out <= 4'h0;
      src_reg <= kpm_pkg::SRC_PANEL;
      dir_reg <= 1'b0;
    end
    else
    begin
      keys_prev_reg <= keys_in;
      state_reg <= state_next;
      group_reg <= group_next;
      param_reg <= param_next;
      edit_reg <= edit_next;
      dsel_reg <= dsel_next;
      status_sel_out <= ssel_next;
      src_reg <= src_next;
      dir_reg <= dir_next;
    end
  end

  // ----------------------------------------------------------------
  // Parameter store
  // ----------------------------------------------------------------
  // The panel's confirm has priority over a bus write to the same entry.
  for (genvar i = 0; i < kpm_pkg::N_PARAMS; i++)
  begin : g_store
    always_ff @(posedge clk_in)
    begin
      if (!nrst_in)
        store_reg[i] <= 20'h00000;
      else if (save && (idx == 4'(i)))
        store_reg[i] <= edit_reg;
      else if (wr_pdata && (pidx_reg == 4'(i)))
        store_reg[i] <= pwdata_in[19:0];
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_next = 32'h00000000;
    mapped = 1'b1;
    if (paddr_in == kpm_pkg::OFS_CONFIG)
      rdata_next = {22'h000000, cfg_reg};
    else if (paddr_in == kpm_pkg::OFS_CTRL)
      rdata_next = {29'h00000000, dir_reg, src_reg};
    else if (paddr_in == kpm_pkg::OFS_LOCK)
      rdata_next = {4'h0, rl_mask_reg, 4'h0, ro_mask_reg};
    else if (paddr_in == kpm_pkg::OFS_PIDX)
      rdata_next = {28'h0000000, pidx_reg};
    else if (paddr_in == kpm_pkg::OFS_PDATA)
      rdata_next = (pidx_reg < 4'(kpm_pkg::N_PARAMS))
                   ? {12'h000, store_reg[pidx_reg]} : 32'h00000000;
    else if (paddr_in == kpm_pkg::OFS_STATUS)
      rdata_next = {12'h000, drive_in, status_sel_out, dir_reg,
                    src_reg, dsel_reg, param_reg, group_reg, state_reg};
    else
      mapped = 1'b0;
  end

  // The answer is prepared in the setup cycle, so every access ends
  // in its first access cycle.
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      pready_out <= 1'b0;
      prdata_out <= 32'h00000000;
      pslverr_out <= 1'b0;
      cfg_reg <= kpm_pkg::CONFIG_RST;
      ro_mask_reg <= kpm_pkg::LOCK_RST;
      rl_mask_reg <= kpm_pkg::LOCK_RST;
      pidx_reg <= 4'h0;
    end
    else
    begin
      pready_out <= setup;
      if (setup)
      begin
        prdata_out <= pwrite_in ? 32'h00000000 : rdata_next;
        pslverr_out <= !mapped;
      end
      if (wr_cfg)
        cfg_reg <= pwdata_in[9:0];
      if (wr_lock)
      begin
        ro_mask_reg <= pwdata_in[11:0];
        rl_mask_reg <= pwdata_in[kpm_pkg::LOCK_RL +: 12];
      end
      if (wr_pidx)
        pidx_reg <= pwdata_in[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Lamps, display and drive commands
  // ----------------------------------------------------------------
  assign glyph = (group_reg == kpm_pkg::G_GEN) ? kpm_pkg::GLY_GEN
               : (group_reg == kpm_pkg::G_ENH) ? kpm_pkg::GLY_ENH
               : kpm_pkg::GLY_MON;

  always_comb
  begin
    lamps_next.run = drive_in.running;
    lamps_next.dir = dir_reg;
    lamps_next.ttf = drive_in.fault ? fast_ph_reg
                   : drive_in.tuning ? slow_ph_reg : drive_in.torque;
    lamps_next.src = (src_reg == kpm_pkg::SRC_TERM)
                     || ((src_reg == kpm_pkg::SRC_COMM) && slow_ph_reg);
    lamps_next.hz = (status_unit_in == kpm_pkg::U_HZ)
                    || (status_unit_in == kpm_pkg::U_RPM);
    lamps_next.amp = (status_unit_in == kpm_pkg::U_AMP)
                     || (status_unit_in == kpm_pkg::U_RPM)
                     || (status_unit_in == kpm_pkg::U_PCT);
    lamps_next.volt = (status_unit_in == kpm_pkg::U_VOLT)
                      || (status_unit_in == kpm_pkg::U_PCT);
    case (state_reg)
      kpm_pkg::M_DISP:
        digits_next = status_value_in;
      kpm_pkg::M_GROUP:
        digits_next = {glyph, {4{kpm_pkg::GLY_BLANK}}};
      kpm_pkg::M_PARAM:
        digits_next = {glyph, kpm_pkg::GLY_BLANK, kpm_pkg::GLY_BLANK,
                       4'h0, 2'b00, param_reg};
      default:
        digits_next = edit_reg;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      lamps_out <= '0;
      digits_out <= 20'h00000;
      digit_dark_out <= 5'h00;
      run_cmd_out <= 1'b0;
      stop_cmd_out <= 1'b0;
      fault_reset_out <= 1'b0;
      reverse_cmd_out <= 1'b0;
      cmd_src_out <= kpm_pkg::SRC_PANEL;
    end
    else
    begin
      lamps_out <= lamps_next;
      digits_out <= digits_next;
      digit_dark_out <= (state_reg == kpm_pkg::M_VALUE && editable
                         && slow_ph_reg) ? 5'(5'h01 << dsel_reg) : 5'h00;
      run_cmd_out <= press[kpm_pkg::K_RUN] && panel_src;
      stop_cmd_out <= press[kpm_pkg::K_STOP] && drive_in.running
                      && stop_ok;
      fault_reset_out <= press[kpm_pkg::K_STOP] && drive_in.fault
                         && stop_ok;
      reverse_cmd_out <= dir_reg;
      cmd_src_out <= src_reg;
    end
  end

endmodule

// [src/kpm_pkg.sv]
package kpm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  // Flash half periods, counted in 1 ms ticks.
  localparam logic [9:0] SLOW_TICKS = 10'h1F4;
  localparam logic [9:0] FAST_TICKS = 10'h07D;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_LOCK = 8'h08;
  localparam logic [7:0] OFS_PIDX = 8'h0C;
  localparam logic [7:0] OFS_PDATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // CONFIG: [7:4] visibility tens, [3:0] ones, [8] mfk, [9] stop.
  localparam int CFG_MFK = 8;
  localparam int CFG_STOP = 9;
  localparam logic [9:0] CONFIG_RST = 10'h211;
  // CTRL: [1:0] command source, [2] reverse.
  localparam int CTRL_DIR = 2;
  // LOCK: [11:0] read-only mask, [27:16] run-lock mask.
  localparam int LOCK_RL = 16;
  localparam logic [11:0] LOCK_RST = 12'h000;

  // ----------------------------------------------------------------
  // Keys, sources, groups, units, glyphs
  // ----------------------------------------------------------------
  localparam int K_MENU = 0;
  localparam int K_ENTER = 1;
  localparam int K_UP = 2;
  localparam int K_DOWN = 3;
  localparam int K_SHIFT = 4;
  localparam int K_RUN = 5;
  localparam int K_MFK = 6;
  localparam int K_STOP = 7;
  localparam logic [1:0] SRC_PANEL = 2'h0;
  localparam logic [1:0] SRC_TERM = 2'h1;
  localparam logic [1:0] SRC_COMM = 2'h2;
  localparam logic [1:0] G_GEN = 2'h0;
  localparam logic [1:0] G_ENH = 2'h1;
  localparam logic [1:0] G_MON = 2'h2;
  localparam logic [2:0] U_HZ = 3'h0;
  localparam logic [2:0] U_AMP = 3'h1;
  localparam logic [2:0] U_VOLT = 3'h2;
  localparam logic [2:0] U_RPM = 3'h3;
  localparam logic [2:0] U_PCT = 3'h4;
  localparam logic [3:0] GLY_BLANK = 4'hF;
  localparam logic [3:0] GLY_GEN = 4'hC;
  localparam logic [3:0] GLY_ENH = 4'hD;
  localparam logic [3:0] GLY_MON = 4'hE;
  localparam logic [3:0] N_STATUS = 4'h8;
  localparam logic [2:0] LAST_DIGIT = 3'h4;
  localparam int N_PARAMS = 12;

  typedef enum logic [1:0] {
    M_DISP = 2'b00,
    M_GROUP = 2'b01,
    M_PARAM = 2'b11,
    M_VALUE = 2'b10
  } kpm_menu_e;

  typedef struct packed {
    logic running;
    logic tuning;
    logic torque;
    logic fault;
  } kpm_drive_s;

  typedef struct packed {
    logic run;
    logic dir;
    logic ttf;
    logic src;
    logic hz;
    logic amp;
    logic volt;
  } kpm_lamps_s;

endpackage

// [dv/kpm_panel_checker.sv]
module kpm_panel_checker (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Bus and keys
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] keys_in,
  input wire kpm_pkg::kpm_drive_s drive_in,
  // Watched outputs
  input wire logic pready_out,
  input wire kpm_pkg::kpm_lamps_s lamps_out,
  input wire logic run_cmd_out,
  input wire logic stop_cmd_out,
  input wire logic reverse_cmd_out,
  input wire logic [1:0] cmd_src_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_run_lit: assert property (
    drive_in.running [*3] |-> lamps_out.run)
    else $error("run lamp dark while running");
  chk_run_dark: assert property (
    !drive_in.running [*3] |-> !lamps_out.run)
    else $error("run lamp lit while stopped");
  chk_dir_lamp: assert property (
    $stable(reverse_cmd_out) [*3] |-> lamps_out.dir == reverse_cmd_out)
    else $error("direction lamp disagrees with rotation");
  chk_torque_steady: assert property (
    (drive_in.torque && !drive_in.tuning && !drive_in.fault) [*3]
    |-> lamps_out.ttf)
    else $error("torque lamp not steady");
  chk_src_panel: assert property (
    (cmd_src_out == kpm_pkg::SRC_PANEL) [*3] |-> !lamps_out.src)
    else $error("source lamp lit under panel control");
  chk_src_term: assert property (
    (cmd_src_out == kpm_pkg::SRC_TERM) [*3] |-> lamps_out.src)
    else $error("source lamp dark under terminal control");
  // The source output is registered beside the run pulse, so both
  // reflect the same cycle.
  chk_run_press: assert property (
    run_cmd_out |-> $past(keys_in[kpm_pkg::K_RUN])
    && !$past(keys_in[kpm_pkg::K_RUN], 2)
    && cmd_src_out == kpm_pkg::SRC_PANEL)
    else $error("run pulse without panel run press");
  chk_stop_press: assert property (
    stop_cmd_out |-> $past(keys_in[kpm_pkg::K_STOP])
    && !$past(keys_in[kpm_pkg::K_STOP], 2))
    else $error("stop pulse without stop press");
  chk_bus_answer: assert property (
    psel_in && !penable_in |=> pready_out ##1 !pready_out)
    else $error("ready not a single cycle after setup");
endmodule

bind kpm_panel kpm_panel_checker u_chk (
  .clk_in(clk_in),
  .nrst_in(nrst_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .keys_in(keys_in),
  .drive_in(drive_in),
  .pready_out(pready_out),
  .lamps_out(lamps_out),
  .run_cmd_out(run_cmd_out),
  .stop_cmd_out(stop_cmd_out),
  .reverse_cmd_out(reverse_cmd_out),
  .cmd_src_out(cmd_src_out)
);

// [dv/kpm_operator.sv]
module kpm_operator (
  // Clock
  input wire logic clk_in,
  // Key levels towards the panel
  output logic [7:0] keys_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial keys_out = 8'h00;
  // A key is held for 1 + hold cycles, then released long enough that
  // the panel sees exactly one rising edge and has settled.
  task automatic press(input int k, input int hold);
    @(posedge clk_in);
    keys_out <= 8'h01 << k;
    repeat (hold + 1) @(posedge clk_in);
    keys_out <= 8'h00;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

// [dv/kpm_panel_bench.sv]
module kpm_panel_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [7:0] keys;
  kpm_pkg::kpm_drive_s drive_in = 4'h0;
  logic [19:0] status_value_in = 20'h12345;
  logic [2:0] status_unit_in = 3'h0;
  kpm_pkg::kpm_lamps_s lamps_out;
  logic [19:0] digits_out;
  logic [4:0] digit_dark_out;
  logic [3:0] status_sel_out;
  logic run_cmd_out;
  logic stop_cmd_out;
  logic fault_reset_out;
  logic reverse_cmd_out;
  logic [1:0] cmd_src_out;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int n_run = 0;
  int n_stop = 0;
  int n_frst = 0;
  wire [7:0] watch = {digit_dark_out[0], lamps_out};
  logic [13:0] rows [5] = '{{4'h0, 3'h0, 7'h04}, {4'h8, 3'h1, 7'h42},
    {4'h2, 3'h2, 7'h11}, {4'hA, 3'h3, 7'h56}, {4'h0, 3'h4, 7'h03}};

  always #4 clk_in = ~clk_in;

  kpm_operator op (.clk_in(clk_in), .keys_out(keys));

  kpm_panel #(.TICK_CYC(4)) dut (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .keys_in(keys), .drive_in(drive_in),
    .status_value_in(status_value_in), .status_unit_in(status_unit_in),
    .lamps_out(lamps_out), .digits_out(digits_out),
    .digit_dark_out(digit_dark_out), .status_sel_out(status_sel_out),
    .run_cmd_out(run_cmd_out), .stop_cmd_out(stop_cmd_out),
    .fault_reset_out(fault_reset_out),
    .reverse_cmd_out(reverse_cmd_out), .cmd_src_out(cmd_src_out)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    n_run <= n_run + run_cmd_out;
    n_stop <= n_stop + stop_cmd_out;
    n_frst <= n_frst + fault_reset_out;
    if (cycles == 40000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // Only pready_out or the bench's cycle ceiling may end this wait.
    do
      @(posedge clk_in);
    while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic state_read();
    apb(1'b0, kpm_pkg::OFS_STATUS, 32'h0);
  endtask

  task automatic do_reset();
    nrst_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
  endtask

  // Counts level changes of one watched bit over more than a slow half period.
  task automatic toggles(input int idx, output int t);
    logic p;
    t = 0;
    p = watch[idx];
    repeat (2100)
    begin
      @(posedge clk_in);
      if (watch[idx] !== p)
        t++;
      p = watch[idx];
    end
  endtask

  initial
  begin
    int t;
    do_reset();
    foreach (rows[i])
    begin
      drive_in <= rows[i][13:10];
      status_unit_in <= rows[i][9:7];
      repeat (4) @(posedge clk_in);
      check("lamps", lamps_out, rows[i][6:0]);
    end
    check("digits", digits_out, 20'h12345);
    op.press(4, 0);
    check("status select", status_sel_out, 4'h1);
    op.press(5, 0);
    check("run pulses", n_run, 1);
    drive_in <= 4'h8;
    op.press(7, 0);
    check("stop pulses", n_stop, 1);
    drive_in <= 4'h1;
    op.press(7, 0);
    check("reset pulses", n_frst, 1);
    toggles(4, t);
    check("fast flash", t > 2, 1'b1);
    drive_in <= 4'h4;
    toggles(4, t);
    check("slow flash", t inside {[1:2]}, 1'b1);
    $display("lamp and key test done");
    drive_in <= 4'h8;
    apb(1'b0, kpm_pkg::OFS_CONFIG, 32'h0);
    check("config", rd, 32'h211);
    check("config error", err, 1'b0);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped", err, 1'b1);
    apb(1'b1, kpm_pkg::OFS_CONFIG, 32'h11);
    apb(1'b1, kpm_pkg::OFS_CTRL, 32'h1);
    check("source lamp", lamps_out.src, 1'b1);
    op.press(5, 0);
    op.press(7, 3);
    check("run refused", n_run, 1);
    check("stop refused", n_stop, 1);
    apb(1'b1, kpm_pkg::OFS_CTRL, 32'h2);
    toggles(3, t);
    check("comm flash", t > 0, 1'b1);
    apb(1'b1, kpm_pkg::OFS_CTRL, 32'h0);
    op.press(6, 0);
    check("mfk source", cmd_src_out, 2'h1);
    apb(1'b1, kpm_pkg::OFS_CONFIG, 32'h111);
    op.press(6, 0);
    check("mfk dir", {reverse_cmd_out, lamps_out.dir}, 2'h3);
    $display("bus test done");
    drive_in <= 4'h0;
    do_reset();
    op.press(0, 0);
    state_read();
    check("menu level", rd[1:0], 2'h1);
    op.press(1, 0);
    op.press(1, 0);
    toggles(7, t);
    check("edit blink", t > 0, 1'b1);
    op.press(2, 0);
    op.press(4, 0);
    op.press(2, 4);
    check("edit digits", digits_out, 20'h00011);
    op.press(1, 0);
    state_read();
    check("next param", rd[5:0], 6'h13);
    apb(1'b0, kpm_pkg::OFS_PDATA, 32'h0);
    check("stored", rd, 32'h11);
    op.press(1, 0);
    op.press(2, 0);
    op.press(0, 0);
    state_read();
    check("same param", rd[5:0], 6'h13);
    apb(1'b1, kpm_pkg::OFS_PIDX, 32'h1);
    apb(1'b0, kpm_pkg::OFS_PDATA, 32'h0);
    check("discarded", rd, 32'h0);
    apb(1'b1, kpm_pkg::OFS_LOCK, 32'h20000);
    drive_in <= 4'h8;
    op.press(1, 0);
    toggles(7, t);
    check("locked blink", t, 0);
    op.press(2, 0);
    op.press(1, 0);
    apb(1'b0, kpm_pkg::OFS_PDATA, 32'h0);
    check("locked", rd, 32'h0);
    drive_in <= 4'h0;
    op.press(3, 0);
    op.press(1, 0);
    op.press(2, 0);
    op.press(1, 0);
    apb(1'b0, kpm_pkg::OFS_PDATA, 32'h0);
    check("unlocked", rd, 32'h1);
    $display("menu test done");
    drive_in <= 4'h0;
    do_reset();
    op.press(0, 0);
    op.press(2, 0);
    state_read();
    check("group", rd[3:2], 2'h1);
    op.press(2, 0);
    state_read();
    check("group", rd[3:2], 2'h2);
    apb(1'b1, kpm_pkg::OFS_CONFIG, 32'h201);
    op.press(3, 0);
    state_read();
    check("enh hidden", rd[3:2], 2'h0);
    apb(1'b1, kpm_pkg::OFS_CONFIG, 32'h210);
    op.press(2, 0);
    op.press(2, 0);
    state_read();
    check("mon hidden", rd[3:2], 2'h0);
    $display("group test done");
    give_verdict();
  end
endmodule
